// >>> design/doc_dev_end.sv
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module doc_dev_end #(
    parameter logic [doc_pkg::ID_W-1:0] VERSION_ID = 2'h0  // Arbitrary value.
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    doc_link_if.dev                         link,
    input  wire logic                       det_i_high,
    input  wire logic                       det_q_high,
    output logic [doc_pkg::CODE_W-1:0]      i_offset_code,
    output logic [doc_pkg::CODE_W-1:0]      q_offset_code,
    output logic                            detector_res_bypass,
    output logic                            detector_cap_bypass,
    output logic                            cal_busy
);

    typedef enum logic {
        DOC_IDLE = 1'b0,
        DOC_RUN  = 1'b1
    } doc_cal_state_t;

    logic                              sclk_s1, sclk_s2, sclk_s3;
    logic                              sdata_s1, sdata_s2;
    logic                              slatch_s1, slatch_s2, slatch_s3;
    logic                              deti_s1, deti_s2, detq_s1, detq_s2;
    logic                              sclk_rise;
    logic                              latch_rise;
    logic [doc_pkg::WORD_W-1:0]        rx_sh;
    logic [doc_pkg::WORD_W-1:0]        rd_sh;
    logic [doc_pkg::WORD_W-1:0]        rd_word;
    logic [doc_pkg::ADDR_W-1:0]        rx_addr;
    logic                              wr_ctl1, wr_ctl2, wr_codes, wr_read;
    logic                              start_write;
    logic                              auto_src;
    logic [doc_pkg::DIV_W-1:0]         div_code;
    logic                              clk_sel;
    logic [doc_pkg::TRIM_W-1:0]        osc_trim;
    logic [doc_pkg::CODE_W-1:0]        man_i, man_q;
    logic [doc_pkg::CODE_W-1:0]        cal_i, cal_q;
    logic [doc_pkg::OSC_CNT_W-1:0]     osc_cnt;
    logic                              osc_tick;
    logic                              src_tick;
    logic [doc_pkg::DIV_CNT_W-1:0]     div_cnt;
    logic                              step;
    logic [2:0]                        bit_idx;
    doc_cal_state_t                    state;

    // Every pin crosses two flip-flops; edge detection looks only at the second and third.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_s1   <= 1'b0;
            sclk_s2   <= 1'b0;
            sclk_s3   <= 1'b0;
            sdata_s1  <= 1'b0;
            sdata_s2  <= 1'b0;
            slatch_s1 <= 1'b0;
            slatch_s2 <= 1'b0;
            slatch_s3 <= 1'b0;
            deti_s1   <= 1'b0;
            deti_s2   <= 1'b0;
            detq_s1   <= 1'b0;
            detq_s2   <= 1'b0;
        end else begin
            sclk_s1   <= link.sclk;
            sclk_s2   <= sclk_s1;
            sclk_s3   <= sclk_s2;
            sdata_s1  <= link.sdata;
            sdata_s2  <= sdata_s1;
            slatch_s1 <= link.slatch;
            slatch_s2 <= slatch_s1;
            slatch_s3 <= slatch_s2;
            deti_s1   <= det_i_high;
            deti_s2   <= deti_s1;
            detq_s1   <= det_q_high;
            detq_s2   <= detq_s1;
        end
    end

    assign sclk_rise  = sclk_s2 & ~sclk_s3;
    assign latch_rise = slatch_s2 & ~slatch_s3;

    // Shift in LSB first; data and clock share the same synchroniser depth, so they stay aligned.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_sh <= '0;
        end else if (sclk_rise) begin
            rx_sh <= {sdata_s2, rx_sh[doc_pkg::WORD_W-1:1]};
        end
    end

    // Word decode on the rising edge of the latch line.
    assign rx_addr     = rx_sh[doc_pkg::ADDR_W-1:0];
    assign wr_read     = latch_rise && (rx_addr == doc_pkg::REG_READBACK);
    assign wr_ctl1     = latch_rise && (rx_addr == doc_pkg::REG_CTL1);
    assign wr_ctl2     = latch_rise && (rx_addr == doc_pkg::REG_CTL2);
    assign wr_codes    = latch_rise && (rx_addr == doc_pkg::REG_CODES);
    assign start_write = wr_ctl2 && rx_sh[doc_pkg::CAL_START_BIT];

    // Detector filter bypass bits.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            detector_res_bypass <= 1'b0;
            detector_cap_bypass <= 1'b0;
        end else if (wr_ctl1) begin
            detector_res_bypass <= rx_sh[doc_pkg::FLT_RES_BIT];
            detector_cap_bypass <= rx_sh[doc_pkg::FLT_CAP_BIT];
        end
    end

    // Calibration controls; the start bit itself lives in the state machine.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            auto_src <= 1'b1;
            div_code <= '0;
            clk_sel  <= 1'b1;
            osc_trim <= doc_pkg::TRIM_RST;
        end else if (wr_ctl2) begin
            auto_src <= rx_sh[doc_pkg::AUTO_SRC_BIT];
            div_code <= rx_sh[doc_pkg::DIV_LSB +: doc_pkg::DIV_W];
            clk_sel  <= rx_sh[doc_pkg::CLK_SEL_BIT];
            osc_trim <= rx_sh[doc_pkg::TRIM_LSB +: doc_pkg::TRIM_W];
        end
    end

    // Codes written by the host for manual adjustment.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            man_i <= doc_pkg::CODE_MID;
            man_q <= doc_pkg::CODE_MID;
        end else if (wr_codes) begin
            man_i <= rx_sh[doc_pkg::I_CODE_LSB +: doc_pkg::CODE_W];
            man_q <= rx_sh[doc_pkg::Q_CODE_LSB +: doc_pkg::CODE_W];
        end
    end

    // Internal oscillator modelled as an enable pulse from a trimmed divider.
    // A start realigns it, so the first step never uses a detector level older than the new code.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            osc_cnt <= '0;
        end else if (osc_tick || start_write) begin
            osc_cnt <= '0;
        end else begin
            osc_cnt <= osc_cnt + 1'b1;
        end
    end

    assign osc_tick = (osc_cnt >= doc_pkg::osc_period(osc_trim) - 1'b1);
    assign src_tick = clk_sel ? osc_tick : sclk_rise;

    // Calibration divider restarts with each calibration so the first step is a full period.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_cnt <= '0;
        end else if (start_write || step) begin
            div_cnt <= '0;
        end else if (state == DOC_RUN && src_tick) begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    assign step = (state == DOC_RUN) && src_tick
                  && (div_cnt == doc_pkg::DIV_RATIO[div_code] - 1'b1);

    // Successive approximation: try each bit from the top; the detector says whether to keep it.
    // A start that lands on the final step wins, so a fresh request is never lost.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state   <= DOC_IDLE;
            bit_idx <= '0;
            cal_i   <= doc_pkg::CODE_MID;
            cal_q   <= doc_pkg::CODE_MID;
        end else if (start_write) begin
            state   <= DOC_RUN;
            bit_idx <= 3'(doc_pkg::CODE_W - 1);
            cal_i   <= doc_pkg::CODE_MID;
            cal_q   <= doc_pkg::CODE_MID;
        end else if (step) begin
            if (deti_s2) begin
                cal_i[bit_idx] <= 1'b0;
            end
            if (detq_s2) begin
                cal_q[bit_idx] <= 1'b0;
            end
            if (bit_idx != 3'h0) begin
                cal_i[bit_idx - 3'h1] <= 1'b1;
                cal_q[bit_idx - 3'h1] <= 1'b1;
                bit_idx               <= bit_idx - 3'h1;
            end else begin
                state <= DOC_IDLE;
            end
        end
    end // Codes change nowhere else.

    assign cal_busy = (state == DOC_RUN);

    // The DACs follow the calibration result or the host's manual codes.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            i_offset_code <= doc_pkg::CODE_MID;
            q_offset_code <= doc_pkg::CODE_MID;
        end else begin
            i_offset_code <= auto_src ? cal_i : man_i;
            q_offset_code <= auto_src ? cal_q : man_q;
        end
    end

    // Readback word: codes high, busy flag in a spare bit so the host can poll for completion.
    always_comb begin
        rd_word                                                  = '0;
        rd_word[doc_pkg::ID_LSB +: doc_pkg::ID_W]                = VERSION_ID;
        rd_word[doc_pkg::BUSY_RD_BIT]                            = cal_busy;
        rd_word[doc_pkg::Q_CODE_LSB +: doc_pkg::CODE_W]          = q_offset_code;
        rd_word[doc_pkg::I_CODE_LSB +: doc_pkg::CODE_W]          = i_offset_code;
    end

    // A write to address zero loads the readback shifter; each serial clock then moves one bit.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_sh <= '0;
        end else if (wr_read) begin
            rd_sh <= rd_word;
        end else if (sclk_rise) begin
            rd_sh <= {1'b0, rd_sh[doc_pkg::WORD_W-1:1]};
        end
    end

    assign link.rdbk = rd_sh[0];

endmodule : doc_dev_end

// >>> design/doc_host_end.sv
`timescale 1ns/100ps
// Serial link master, ordered by software over a classic Wishbone slave port.
module doc_host_end (
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [doc_pkg::WB_ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]                  wb_dat_i,
    input  wire logic [3:0]                   wb_sel_i,
    output logic [31:0]                       wb_dat_o,
    output logic                              wb_ack_o,
    doc_link_if.host                          link
);

    typedef enum logic [1:0] {
        DOC_H_IDLE  = 2'b00,
        DOC_H_SHIFT = 2'b01,
        DOC_H_LATCH = 2'b11
    } doc_host_state_t;

    logic                              wb_req;
    logic                              wb_wr;
    logic [doc_pkg::WORD_W-1:0]        tx_word;
    logic [doc_pkg::WORD_W-1:0]        tx_sh;
    logic [doc_pkg::WORD_W-1:0]        rx_word;
    logic                              rd_mode;
    logic                              rdbk_s1, rdbk_s2;
    logic [2:0]                        half_cnt;
    logic                              half_tick;
    logic [doc_pkg::WORD_CNT_W-1:0]    bit_cnt;
    logic                              go_send, go_read;
    doc_host_state_t                   state;

    assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr   = wb_req && wb_we_i;
    // Orders arriving while a frame runs are dropped.
    assign go_send = wb_wr && (wb_adr_i == doc_pkg::WB_CTRL) && wb_sel_i[0]
                     && wb_dat_i[doc_pkg::CTRL_SEND_BIT] && (state == DOC_H_IDLE);
    assign go_read = wb_wr && (wb_adr_i == doc_pkg::WB_CTRL) && wb_sel_i[0]
                     && wb_dat_i[doc_pkg::CTRL_READ_BIT] && !go_send && (state == DOC_H_IDLE);

    // One wait state: ack follows the request by one cycle and drops after one.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    doc_pkg::WB_TX_WORD: wb_dat_o <= tx_word;
                    doc_pkg::WB_STATUS:  wb_dat_o <= {31'h0, state != DOC_H_IDLE};
                    doc_pkg::WB_RX_WORD: wb_dat_o <= rx_word;
                    default:             wb_dat_o <= '0;
                endcase
            end
        end
    end

    // Outgoing word, byte lanes honoured.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_word <= '0;
        end else if (wb_wr && wb_adr_i == doc_pkg::WB_TX_WORD) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    tx_word[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    // Readback line comes from a pin and is synchronised before use.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdbk_s1 <= 1'b0;
            rdbk_s2 <= 1'b0;
        end else begin
            rdbk_s1 <= link.rdbk;
            rdbk_s2 <= rdbk_s1;
        end
    end

    // Half-period enable for the serial clock.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            half_cnt <= '0;
        end else if (state == DOC_H_IDLE || half_tick) begin
            half_cnt <= '0;
        end else begin
            half_cnt <= half_cnt + 3'h1;
        end
    end

    assign half_tick = (half_cnt == 3'(doc_pkg::SCLK_HALF_CYC - 1));

    // Frame sequencer: data changes on the falling clock; readback is taken just before rising.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state       <= DOC_H_IDLE;
            link.sclk   <= 1'b0;
            link.sdata  <= 1'b0;
            link.slatch <= 1'b0;
            tx_sh       <= '0;
            rx_word     <= '0;
            rd_mode     <= 1'b0;
            bit_cnt     <= '0;
        end else begin
            unique case (state)
                DOC_H_IDLE: begin
                    if (go_send || go_read) begin
                        state      <= DOC_H_SHIFT;
                        rd_mode    <= go_read;
                        tx_sh      <= {1'b0, tx_word[doc_pkg::WORD_W-1:1]};
                        link.sdata <= go_send ? tx_word[0] : 1'b0;
                        bit_cnt    <= '0;
                    end
                end
                DOC_H_SHIFT: begin
                    if (half_tick) begin
                        if (!link.sclk) begin
                            link.sclk <= 1'b1;
                            if (rd_mode) begin
                                rx_word <= {rdbk_s2, rx_word[doc_pkg::WORD_W-1:1]};
                            end
                        end else begin
                            link.sclk  <= 1'b0;
                            link.sdata <= rd_mode ? 1'b0 : tx_sh[0];
                            tx_sh      <= {1'b0, tx_sh[doc_pkg::WORD_W-1:1]};
                            bit_cnt    <= bit_cnt + 1'b1;
                            if (bit_cnt == '1) begin
                                state <= rd_mode ? DOC_H_IDLE : DOC_H_LATCH;
                            end
                        end
                    end
                end
                DOC_H_LATCH: begin
                    if (half_tick) begin
                        if (!link.slatch) begin
                            link.slatch <= 1'b1;
                        end else begin
                            link.slatch <= 1'b0;
                            state       <= DOC_H_IDLE;
                        end
                    end
                end
                default: state <= DOC_H_IDLE;
            endcase
        end
    end

endmodule : doc_host_end

// >>> design/doc_link_if.sv
`timescale 1ns/100ps
// Three-wire serial link plus the readback line.
interface doc_link_if;
    logic sclk;
    logic sdata;
    logic slatch;
    logic rdbk;

    modport dev  (input sclk, input sdata, input slatch, output rdbk);
    modport host (output sclk, output sdata, output slatch, input rdbk);
endinterface : doc_link_if

// >>> design/doc_pkg.sv
package doc_pkg;

    // System clock and the derived link timing.
    localparam int CLK_HZ        = 10_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int CLK_KHZ       = CLK_HZ / 1000;
    // Half period of the serial clock; long enough for the two-stage pin synchronisers.
    localparam int SCLK_HALF_NS  = 400;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Serial word layout: the register address sits in the low bits, shifted LSB first.
    localparam int WORD_W     = 32;
    localparam int ADDR_W     = 3;
    localparam int WORD_CNT_W = 5;
    localparam logic [ADDR_W-1:0] REG_READBACK = 3'h0;
    localparam logic [ADDR_W-1:0] REG_CTL1     = 3'h1;
    localparam logic [ADDR_W-1:0] REG_CTL2     = 3'h2;
    localparam logic [ADDR_W-1:0] REG_CODES    = 3'h3;

    // Control register 1 fields.
    localparam int FLT_RES_BIT = 25;
    localparam int FLT_CAP_BIT = 26;

    // Control register 2 fields.
    localparam int CAL_START_BIT = 5;
    localparam int AUTO_SRC_BIT  = 24;
    localparam int DIV_LSB       = 25;
    localparam int DIV_W         = 3;
    localparam int CLK_SEL_BIT   = 28;
    localparam int TRIM_LSB      = 29;
    localparam int TRIM_W        = 3;
    localparam logic [TRIM_W-1:0] TRIM_RST = 3'h3;

    // Offset codes: positions in the code register and in the readback word.
    localparam int CODE_W     = 8;
    localparam int Q_CODE_LSB = 16;
    localparam int I_CODE_LSB = 24;
    localparam logic [CODE_W-1:0] CODE_MID = 8'h80;
    localparam int ID_LSB      = 5;
    localparam int ID_W        = 2;
    localparam int BUSY_RD_BIT = 7;

    // Internal oscillator frequency per trim code, in kHz.
    localparam int OSC_KHZ [8] = '{300, 500, 700, 900, 1100, 1300, 1500, 1800};
    localparam int OSC_CNT_W   = 6;

    // Calibration clock divider ratio per divider code.
    localparam int DIV_CNT_W = 11;
    localparam logic [DIV_CNT_W-1:0] DIV_RATIO [8] = '{11'h001, 11'h002, 11'h004, 11'h008,
                                                       11'h010, 11'h040, 11'h100, 11'h400};

    // Host Wishbone register offsets.
    localparam int WB_ADR_W = 8;
    localparam logic [WB_ADR_W-1:0] WB_TX_WORD = 8'h00;
    localparam logic [WB_ADR_W-1:0] WB_CTRL    = 8'h04;
    localparam logic [WB_ADR_W-1:0] WB_STATUS  = 8'h08;
    localparam logic [WB_ADR_W-1:0] WB_RX_WORD = 8'h0C;
    localparam int CTRL_SEND_BIT = 0;
    localparam int CTRL_READ_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;

    // Oscillator period in system clock cycles, rounded down.
    function automatic logic [OSC_CNT_W-1:0] osc_period(input logic [TRIM_W-1:0] trim);
        return OSC_CNT_W'(CLK_KHZ / OSC_KHZ[trim]);
    endfunction : osc_period

endpackage : doc_pkg

// >>> testbench/dc_offset_cal_control_test.sv
`timescale 1ns/100ps
// Drives the host end over Wishbone and plays the offset detector for the device end.
module dc_offset_cal_control_test;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] dat     = 32'h0;
    logic [3:0]  sel     = 4'h0;
    logic [31:0] rq;
    logic [31:0] rdat;
    logic        ack;
    logic        det_i   = 1'b0;
    logic        det_q   = 1'b0;
    logic [7:0]  ti      = 8'h80;
    logic [7:0]  tq      = 8'h80;
    logic [7:0]  ic;
    logic [7:0]  qc;
    logic        res_byp;
    logic        cap_byp;
    logic        busy;
    int          err_count       = 0;
    int          samples_checked = 0;
    int          n;
    doc_link_if link ();

    doc_host_end i_doc_host_end (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rq),
        .wb_ack_o(ack), .link(link));
    doc_dev_end i_doc_dev_end (.clk_sys(clk_sys), .rst(rst), .link(link), .det_i_high(det_i),
        .det_q_high(det_q), .i_offset_code(ic), .q_offset_code(qc),
        .detector_res_bypass(res_byp), .detector_cap_bypass(cap_byp), .cal_busy(busy));
    doc_link_sva i_doc_link_sva (.clk_sys(clk_sys), .rst(rst), .sclk(link.sclk),
        .sdata(link.sdata), .slatch(link.slatch), .i_offset_code(ic), .q_offset_code(qc),
        .detector_res_bypass(res_byp), .detector_cap_bypass(cap_byp), .cal_busy(busy));

    // The clock runs at 10 MHz.
    always #50 clk_sys = ~clk_sys;

    // The detector reports a code above the target; its lag is far below one search step.
    always @(posedge clk_sys) begin
        det_i <= ic > ti;
        det_q <= qc > tq;
    end

    task automatic results();
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic check_cnt(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("unexpected at %0t: cycles %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : check_cnt

    // One classic Wishbone cycle; the request stands until ack is sampled high.
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {cyc, stb, we} <= {2'b11, wr};
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        @(posedge clk_sys);
        while (ack !== 1'b1) @(posedge clk_sys);
        rdat = rq;
        {cyc, stb} <= 2'b00;
    endtask : wb

    task automatic idle();
        wb(1'b0, doc_pkg::WB_STATUS, 32'h0);
        while (rdat[0] !== 1'b0) wb(1'b0, doc_pkg::WB_STATUS, 32'h0);
    endtask : idle

    task automatic send(input logic [31:0] v);
        wb(1'b1, doc_pkg::WB_TX_WORD, v);
        wb(1'b1, doc_pkg::WB_CTRL, 32'h1);
        idle();
    endtask : send

    // Loads the readback word, then clocks it out; the result lands in rdat.
    task automatic rdback();
        send(32'h0);
        wb(1'b1, doc_pkg::WB_CTRL, 32'h2);
        idle();
        wb(1'b0, doc_pkg::WB_RX_WORD, 32'h0);
    endtask : rdback

    function automatic logic [31:0] ctl2(input logic st, input logic au, input logic [2:0] dv,
                                         input logic cs);
        return {doc_pkg::TRIM_RST, cs, dv, au, 18'h0, st, 2'h0, doc_pkg::REG_CTL2};
    endfunction : ctl2

    // Starts a search from the oscillator and counts the busy cycles seen after the frame.
    task automatic cal(input logic [2:0] dv, output int c);
        send(ctl2(1'b1, 1'b1, dv, 1'b1));
        for (c = 0; c < 30000 && busy === 1'b1; c++) @(posedge clk_sys);
    endtask : cal

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check({ic, qc, busy, link.sclk, link.slatch}, 19'h40400);
        rdback();
        check(rdat, 32'h80800000);
        wb(1'b0, 8'h10, 32'h0);
        check(rdat, 32'h0);
        for (int f = 0; f < 4; f++) begin
            send({5'h0, 2'(f), 22'h0, doc_pkg::REG_CTL1});
            check({res_byp, cap_byp}, {f[0], f[1]});
        end
        ti <= 8'h5A;
        tq <= 8'hC3;
        send(ctl2(1'b1, 1'b1, 3'h4, 1'b1));
        rdback();
        check(rdat & 32'h80, 32'h80);
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk_sys);
        rdback();
        check(rdat, 32'h5AC30000);
        ti <= 8'h11;
        tq <= 8'hEE;
        repeat (2000) @(posedge clk_sys);
        check({ic, qc}, 16'h5AC3);
        send(ctl2(1'b0, 1'b0, 3'h0, 1'b1));
        send({8'h21, 8'hE4, 13'h0, doc_pkg::REG_CODES});
        check({ic, qc}, 16'h21E4);
        rdback();
        check(rdat, 32'h21E40000);
        send(ctl2(1'b0, 1'b1, 3'h0, 1'b1));
        check({ic, qc}, 16'h5AC3);
        // With the serial clock chosen the search waits for frames to supply ticks.
        ti <= 8'h40;
        tq <= 8'h9D;
        send(ctl2(1'b1, 1'b1, 3'h0, 1'b0));
        repeat (600) @(posedge clk_sys);
        check(busy, 1'b1);
        send(32'h0);
        check({busy, ic, qc}, 17'h0409D);
        // Narrow detector with ratio 1024: no step may come within 2000 cycles of the start.
        send({5'h0, 2'h0, 22'h0, doc_pkg::REG_CTL1});
        send(ctl2(1'b1, 1'b1, 3'h7, 1'b1));
        repeat (2000) @(posedge clk_sys);
        check({res_byp, cap_byp, busy, ic, qc}, 19'h18080);
        // Ratio 1024 is left out: eight of its steps would swallow the whole run.
        // Eight steps of eleven cycles per oscillator tick at the default trim, times the ratio.
        for (int d = 0; d < 7; d++) begin
            cal(3'(d), n);
            check_cnt(n, 88 * doc_pkg::DIV_RATIO[d] - 16,
                      88 * doc_pkg::DIV_RATIO[d] + 8);
        end
        results();
    end

    // Cuts a hang short well after the longest expected run.
    initial begin
        #8_000_000;
        err_count++;
        results();
    end
endmodule : dc_offset_cal_control_test

// >>> testbench/doc_link_sva.sv
`timescale 1ns/100ps
// Checks the serial framing and the code, filter and busy outputs of the device in the connected pair.
module doc_link_sva (
    input wire logic                       clk_sys,
    input wire logic                       rst,
    input wire logic                       sclk,
    input wire logic                       sdata,
    input wire logic                       slatch,
    input wire logic [doc_pkg::CODE_W-1:0] i_offset_code,
    input wire logic [doc_pkg::CODE_W-1:0] q_offset_code,
    input wire logic                       detector_res_bypass,
    input wire logic                       detector_cap_bypass,
    input wire logic                       cal_busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // A register write lands a few cycles after the latch pulse begins.
    sequence recent_latch;
        slatch || $past(slatch) || $past(slatch, 2) || $past(slatch, 3);
    endsequence
    // Codes may move only while calibrating, up to two cycles after it, or after a latch.
    sequence code_cause;
        cal_busy || $past(cal_busy) || $past(cal_busy, 2) || slatch || $past(slatch)
            || $past(slatch, 2) || $past(slatch, 3);
    endsequence

    latch_len_a: assert property ($rose(slatch) |-> slatch[*4] ##1 !slatch)
        else $error("latch pulse length wrong");
    sclk_half_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("serial clock high phase wrong");
    data_hold_a: assert property ($rose(sclk) |-> $stable(sdata)[*4])
        else $error("serial data moved while clock high");
    latch_idle_a: assert property (slatch |-> !sclk)
        else $error("serial clock active during latch");
    mid_reset_a: assert property ($fell(rst) |-> i_offset_code == 8'h80
        && q_offset_code == 8'h80 && !cal_busy) else $error("codes not mid-scale after reset");
    cal_mid_a: assert property ($rose(cal_busy) |-> ##[1:2]
        (i_offset_code == 8'h80 && q_offset_code == 8'h80)) else $error("search not from mid");
    code_hold_a: assert property ($changed({i_offset_code, q_offset_code})
        |-> code_cause) else $error("offset codes changed without cause");
    flt_latch_a: assert property ($changed({detector_res_bypass, detector_cap_bypass})
        |-> recent_latch) else $error("filter bypass changed without write");
endmodule : doc_link_sva
